// *** src/sdl_map.svh ***
/*
 Register offsets, field positions, reset values and timing figures
 of the step command decoder. Assumes a 100 MHz clock and 32-bit
 AXI4-Lite word addressing.
*/
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH
// What this block does
// - Position mode takes commands on two inputs
// - Every format can invert command sign
// - Zero accel: bypass smoothing with digital source, else no motion
// - Step pulse moves one step, level sets direction
// - Step counted on chosen rising or falling edge
// - Each step scaled by programmable gear value
// - Up input steps plus, down input steps minus
// - Quadrature A/B decoded to speed and direction
// - Quadrature counts scaled by programmable gear
// - Inputs 2 to 12 selectable as limits
// - Network node may select a home switch
// - Current/velocity: block travel toward active limit
// - Position: limit latches command ignore until cleared
// - Limit active outside current mode: fast green blink and warning
// - Re-enabled at limit: move only away
// - Hold option: no motion while limit active in position mode
// - Hold option disables limits in current/velocity
// ************************************************************
// Register byte offsets
// ************************************************************
`define SDL_CTRL 8'h00
`define SDL_GEAR 8'h04
`define SDL_ACCEL 8'h08
`define SDL_LSEL 8'h0C
`define SDL_STAT 8'h10
`define SDL_POS 8'h14
`define SDL_ISTAT 8'h18
`define SDL_IMASK 8'h1C
// ************************************************************
// Control fields
// ************************************************************
`define SDL_C_EN 0
`define SDL_C_MODE 1
`define SDL_C_FMT 3
`define SDL_C_INV 5
`define SDL_C_FALL 6
`define SDL_C_HOLD 7
`define SDL_C_SRCDIG 8
`define SDL_C_NODE 9
`define SDL_C_CLR 10
`define SDL_CTRL_RST 32'h0000_0000
`define SDL_GEAR_RST 32'h0000_0001
`define SDL_LSEL_RST 32'h0000_0000
// ************************************************************
// Timing
// ************************************************************
`define SDL_CLK_MHZ 100
`define SDL_FAST_HALF_MS 100
`define SDL_SLOW_DIV 4
`endif

// *** src/sdl_pkg.sv ***
/*
 Types of the step command decoder: operating modes and input formats.
 Assumes the control register stores them in two-bit fields.
*/
package sdl_pkg;
  typedef enum logic [1:0] {SDL_CUR, SDL_VEL, SDL_POS, SDL_RSV} sdl_mode_t;
  typedef enum logic [1:0] {SDL_PD, SDL_UD, SDL_QD, SDL_FRSV} sdl_fmt_t;
  typedef enum logic [1:0] {SDL_LED_SLOW, SDL_LED_ON, SDL_LED_FAST} sdl_led_t;
endpackage : sdl_pkg

// *** src/sdl_top.sv ***
/*
 Step command decoder with limit switch gating, AXI4-Lite registers
 and one level interrupt. Assumes inputs in_a, in_b and din are
 asynchronous pins and nrst is an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`include "sdl_map.svh"
module sdl_top
  import sdl_pkg::*;
#(
  parameter int N_IN = 12,
  parameter int FAST_HALF = `SDL_FAST_HALF_MS * 1000 * `SDL_CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_a,
  input wire logic in_b,
  input wire logic [N_IN:1] din,
  output logic [31:0] pos_cmd,
  output logic step_pulse,
  output logic step_dir,
  output logic drive_ok_pos,
  output logic drive_ok_neg,
  output logic smooth_bypass,
  output logic motion_stop,
  output logic limit_warn,
  output logic home_sw,
  output logic led_green,
  output logic irq
);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int FH = (FAST_HALF < 1) ? 1 : FAST_HALF;

  // ************************************************************
  // Reset release and input synchronisers
  // ************************************************************
  logic [1:0] rs_q;
  logic rst_n;
  // Release is synchronous so no flop sees a runt reset edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rs_q <= 2'h0;
    else rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_n = rs_q[1];

  logic [N_IN+1:0] m_q, s_q;
  logic a_p_q, b_p_q;
  logic a_s, b_s;
  logic [N_IN:1] din_s;
  // Two flops per pin; s_q feeds logic, and a third flop on in_a and in_b feeds edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= '0;
      s_q <= '0;
      a_p_q <= 1'b0;
      b_p_q <= 1'b0;
    end else begin
      m_q <= {din, in_b, in_a};
      s_q <= m_q;
      a_p_q <= s_q[0];
      b_p_q <= s_q[1];
    end
  end
  assign a_s = s_q[0];
  assign b_s = s_q[1];
  assign din_s = s_q[N_IN+1:2];

  // ************************************************************
  // Registers
  // ************************************************************
  logic [31:0] ctrl_q, gear_q, accel_q, lsel_q, ist_q, imask_q, pos_q;
  logic aw_ok_q, w_ok_q, bvalid_q, rvalid_q, clr_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rdata_q, stat;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr, wr_ctrl;
  logic [2:0] ev;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `SDL_IMASK;
  endfunction : mapped

  assign s_axi_awready = !aw_ok_q && !bvalid_q;
  assign s_axi_wready = !w_ok_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign do_wr = aw_ok_q && w_ok_q && !bvalid_q;
  assign wr_ctrl = do_wr && awa_q == `SDL_CTRL;

  // Address and data are caught in either order, then written together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      bvalid_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bresp_q <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awa_q) ? RESP_OK : RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Software-owned settings; the clear bit is a one-cycle strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SDL_CTRL_RST;
      gear_q <= `SDL_GEAR_RST;
      accel_q <= 32'h0;
      lsel_q <= `SDL_LSEL_RST;
      imask_q <= 32'h0;
      clr_q <= 1'b0;
    end else begin
      clr_q <= wr_ctrl && ws_q[1] && wd_q[`SDL_C_CLR];
      if (do_wr) begin
        case (awa_q)
          `SDL_CTRL: ctrl_q <= merge(ctrl_q, wd_q, ws_q) & 32'h0000_03FF;
          `SDL_GEAR: gear_q <= merge(gear_q, wd_q, ws_q);
          `SDL_ACCEL: accel_q <= merge(accel_q, wd_q, ws_q);
          `SDL_LSEL: lsel_q <= merge(lsel_q, wd_q, ws_q) & 32'h0000_0FFF;
          `SDL_IMASK: imask_q <= merge(imask_q, wd_q, ws_q) & 32'h0000_0007;
          default: ;
        endcase
      end
    end
  end

  // Sticky events: a new event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ist_q <= 32'h0;
    else if (do_wr && awa_q == `SDL_ISTAT && ws_q[0])
      ist_q <= (ist_q & ~{29'h0, wd_q[2:0]}) | {29'h0, ev};
    else ist_q <= ist_q | {29'h0, ev};
  end
  assign irq = |(ist_q & imask_q);

  // Reads answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
      case (s_axi_araddr)
        `SDL_CTRL: rdata_q <= ctrl_q;
        `SDL_GEAR: rdata_q <= gear_q;
        `SDL_ACCEL: rdata_q <= accel_q;
        `SDL_LSEL: rdata_q <= lsel_q;
        `SDL_STAT: rdata_q <= stat;
        `SDL_POS: rdata_q <= pos_q;
        `SDL_ISTAT: rdata_q <= ist_q;
        `SDL_IMASK: rdata_q <= imask_q;
        default: rdata_q <= 32'h0;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ************************************************************
  // Limit switches
  // ************************************************************
  sdl_mode_t mode;
  sdl_fmt_t fmt;
  logic en, hold, lp, ln, lany, en_p_q, lany_p_q, ign_q, ok_p, ok_n;
  assign mode = sdl_mode_t'(ctrl_q[`SDL_C_MODE +: 2]);
  assign fmt = sdl_fmt_t'(ctrl_q[`SDL_C_FMT +: 2]);
  assign en = ctrl_q[`SDL_C_EN];
  assign hold = ctrl_q[`SDL_C_HOLD];

  // Only inputs 2..12 may act as switches; other codes mean unused
  function automatic logic pick(input logic [3:0] n, input logic [N_IN:1] v);
    logic r;
    r = 1'b0;
    for (int i = 2; i <= N_IN; i++) begin
      if (n == 4'(i)) r = v[i];
    end
    return r;
  endfunction : pick

  assign lp = pick(lsel_q[3:0], din_s);
  assign ln = pick(lsel_q[7:4], din_s);
  assign lany = lp || ln;
  assign home_sw = ctrl_q[`SDL_C_NODE] && pick(lsel_q[11:8], din_s);

  // Hold blocks both ways in position mode but leaves the other modes
  // unguarded, as shipped drives do; users must clear it when switching
  always_comb begin
    if (mode == SDL_POS && hold) begin
      ok_p = !lany;
      ok_n = !lany;
    end else if (mode != SDL_POS && hold) begin
      ok_p = 1'b1;
      ok_n = 1'b1;
    end else begin
      ok_p = !lp;
      ok_n = !ln;
    end
  end
  assign drive_ok_pos = ok_p;
  assign drive_ok_neg = ok_n;

  // Latch set by a new limit while enabled in position mode; re-enable, a clear or leaving position mode ends it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ign_q <= 1'b0;
      en_p_q <= 1'b0;
      lany_p_q <= 1'b0;
    end else begin
      en_p_q <= en;
      lany_p_q <= lany;
      if (mode == SDL_POS && en && lany && !lany_p_q) ign_q <= 1'b1;
      else if ((en && !en_p_q) || clr_q || mode != SDL_POS) ign_q <= 1'b0;
    end
  end
  assign limit_warn = en && lany && mode != SDL_CUR;

  // ************************************************************
  // Command decode
  // ************************************************************
  logic fall, ea, eb, qen, sev, sup, dir, go, hit;
  assign fall = ctrl_q[`SDL_C_FALL];
  assign ea = fall ? (!a_s && a_p_q) : (a_s && !a_p_q);
  assign eb = fall ? (!b_s && b_p_q) : (b_s && !b_p_q);
  assign qen = a_s ^ a_p_q ^ b_s ^ b_p_q;

  // One step per qualifying event; double changes in quadrature are lost
  always_comb begin
    case (fmt)
      SDL_PD: begin
        sev = ea;
        sup = b_s;
      end
      SDL_UD: begin
        sev = ea ^ eb;
        sup = ea;
      end
      SDL_QD: begin
        sev = qen;
        sup = a_s ^ b_p_q;
      end
      default: begin
        sev = 1'b0;
        sup = 1'b0;
      end
    endcase
  end
  assign dir = sup ^ ctrl_q[`SDL_C_INV];
  assign smooth_bypass = accel_q == 32'h0 && ctrl_q[`SDL_C_SRCDIG];
  assign motion_stop = accel_q == 32'h0 && !ctrl_q[`SDL_C_SRCDIG];
  assign hit = sev && mode == SDL_POS && en;
  assign go = hit && !ign_q && !motion_stop && (dir ? ok_p : ok_n);

  // Gear applies to every format alike; position wraps at 32 bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 32'h0;
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
    end else begin
      step_pulse <= go;
      if (go) begin
        step_dir <= dir;
        pos_q <= dir ? pos_q + gear_q : pos_q - gear_q;
      end
    end
  end
  assign pos_cmd = pos_q;
  assign ev = {go, hit && !go, en && lany && !lany_p_q};
  assign stat = {26'h0, motion_stop, smooth_bypass, ign_q, home_sw, ln, lp};

  // ************************************************************
  // Status light
  // ************************************************************
  logic [$clog2(FH+1)-1:0] bc_q;
  logic [1:0] sc_q;
  logic ft_q, st_q;
  sdl_led_t led;
  // One divider; slow blink is every fourth fast toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bc_q <= '0;
      sc_q <= 2'h0;
      ft_q <= 1'b0;
      st_q <= 1'b0;
    end else if (bc_q == ($clog2(FH+1))'(FH - 1)) begin
      bc_q <= '0;
      ft_q <= !ft_q;
      sc_q <= sc_q + 2'h1;
      if (sc_q == 2'(`SDL_SLOW_DIV - 1)) st_q <= !st_q;
    end else begin
      bc_q <= bc_q + 1'b1;
    end
  end
  assign led = !en ? SDL_LED_SLOW : (limit_warn ? SDL_LED_FAST : SDL_LED_ON);
  always_comb begin
    case (led)
      SDL_LED_FAST: led_green = ft_q;
      SDL_LED_ON: led_green = 1'b1;
      default: led_green = st_q;
    endcase
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence pos_limit_hit;
    mode == SDL_POS && en && lany && !lany_p_q;
  endsequence
  // Nothing that ends the latch: no enable rise, no clear, no mode change
  sequence latch_kept;
    (mode == SDL_POS && !(en && !en_p_q) && !clr_q)[*2];
  endsequence

  bypass_sel_a: assert property (smooth_bypass |-> !motion_stop && accel_q == 32'h0)
    else $error("bypass without zero accel");
  pd_step_a: assert property (fmt == SDL_PD && go |=> step_pulse && step_dir == $past(dir))
    else $error("pulse step lost");
  gear_add_a: assert property (step_pulse && step_dir |-> pos_q == $past(pos_q) + $past(gear_q))
    else $error("gear add wrong");
  ud_neg_a: assert property (fmt == SDL_UD && go && eb && !ctrl_q[`SDL_C_INV]
    |=> !step_dir && pos_q == $past(pos_q) - $past(gear_q))
    else $error("down step wrong");
  latch_set_a: assert property (pos_limit_hit ##1 latch_kept |-> ign_q)
    else $error("limit latch not held");
  ign_drop_a: assert property (ign_q |=> !step_pulse)
    else $error("step while ignored");
  hold_all_a: assert property (mode == SDL_POS && hold && lany |=> !step_pulse)
    else $error("motion under hold");
  toward_a: assert property (mode != SDL_POS && !hold && lp |-> !drive_ok_pos && drive_ok_neg == !ln)
    else $error("drive toward limit");
  fast_led_a: assert property (limit_warn && en |-> led_green == ft_q)
    else $error("limit light wrong");
endmodule : sdl_top

// *** tb/sdl_src_model.sv ***
/*
 Behavioural far-side controller for the step command decoder: makes
 step/direction, up/down and quadrature pin activity on request.
 Assumes the caller enters each task just after a rising clock edge.
*/
`timescale 1ns/1ns
module sdl_src_model
  import sdl_pkg::*;
(
  input wire logic clk,
  output logic in_a,
  output logic in_b
);
  // ************************************************************
  // Pin state
  // ************************************************************
  // Quadrature phase index; A leads B for a plus count
  logic [1:0] qidx;
  initial begin
    in_a = 1'b0;
    in_b = 1'b0;
    qidx = 2'h0;
  end
  // Hold a level; the decoder needs each level for at least 1 clock
  task automatic hold_for(input int n);
    repeat (n) @(posedge clk);
  endtask : hold_for
  // Return both pins low so a format change sees no stray edge
  task automatic park();
    qidx = 2'h0;
    in_a <= 1'b0;
    in_b <= 1'b0;
    hold_for(6);
  endtask : park
  // One step in the given format and direction
  task automatic step(input sdl_fmt_t fmt, input logic dir, input int n);
    if (fmt == SDL_QD) begin
      qidx = dir ? qidx + 2'h1 : qidx - 2'h1;
      in_a <= ^qidx;
      in_b <= qidx[1];
      hold_for(n);
    end else if (fmt == SDL_UD) begin
      if (dir) in_a <= 1'b1;
      else in_b <= 1'b1;
      hold_for(n);
      in_a <= 1'b0;
      in_b <= 1'b0;
      hold_for(n);
    end else begin
      in_b <= dir;
      hold_for(n);
      in_a <= 1'b1;
      hold_for(n);
      in_a <= 1'b0;
      hold_for(n);
    end
  endtask : step
endmodule : sdl_src_model

// *** tb/tb.sv ***
/*
 Self-checking bench of the step command decoder: AXI4-Lite register
 access, all input formats, limit gating, home switch and interrupt.
 Assumes the decoder answers AXI requests and the far-side model.
*/
`timescale 1ns/1ns
`include "sdl_map.svh"
module tb;
  import sdl_pkg::*;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, in_a, in_b, lvl, ud_neg, inv, fall, dir;
  logic step_pulse, step_dir, ok_pos, ok_neg, bypass, mstop, warn, home, led, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, pos_cmd, d, p0, g;
  logic [1:0] bresp, rresp, last_resp;
  logic [12:1] din;
  int fail_count, cmp_count, cyc, npulse, n0;
  // ************************************************************
  // Design, far side and clock
  // ************************************************************
  sdl_top #(.N_IN(12), .FAST_HALF(8)) dut_u (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_a(in_a), .in_b(in_b), .din(din), .pos_cmd(pos_cmd), .step_pulse(step_pulse),
    .step_dir(step_dir), .drive_ok_pos(ok_pos), .drive_ok_neg(ok_neg),
    .smooth_bypass(bypass), .motion_stop(mstop), .limit_warn(warn),
    .home_sw(home), .led_green(led), .irq(irq));
  sdl_src_model src_u (.clk(clk), .in_a(in_a), .in_b(in_b));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // Count steps and note the pin level when each one lands
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
    if (step_pulse === 1'b1) begin
      npulse <= npulse + 1;
      lvl <= ud_neg ? in_b : in_a;
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Ready lines are combinational, so they are read before this edge lands
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    last_resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    last_resp = rresp;
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // One unit-gear step/direction move and its expected outcome
  task automatic try_step(input logic up, input logic ok);
    p0 = pos_cmd;
    src_u.step(SDL_PD, up, 6);
    wt(3);
    chk("gated pos", pos_cmd, ok ? (up ? p0 + 1 : p0 - 1) : p0);
  endtask : try_step
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {nrst, awvalid, wvalid, arvalid, awaddr, araddr, wdata, din} = '0;
    {bready, rready, ud_neg} = 3'b110;
    {fail_count, cmp_count, cyc, npulse} = '0;
    void'($urandom(55));
    wt(3);
    nrst <= 1'b1;
    wt(3);
    rd(`SDL_CTRL, d);
    chk("ctrl rst", d, `SDL_CTRL_RST);
    rd(`SDL_GEAR, d);
    chk("gear rst", d, `SDL_GEAR_RST);
    rd(8'h20, d);
    chk("unmapped rd", {d[31:2], last_resp}, 32'h2);
    wr(8'h20, 32'h1);
    chk("unmapped wr", last_resp, 2'h2);
    $display("test registers done");
    // Random moves over every format; gear, sign and edge vary
    wr(`SDL_ACCEL, 32'h0);
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 6; k++) begin
        g = (k == 0) ? 32'h1 : $urandom_range(2, 200);
        {inv, fall, dir} = 3'($urandom);
        wr(`SDL_CTRL, 32'h0);
        src_u.park();
        wr(`SDL_GEAR, g);
        wr(`SDL_CTRL, 32'h105 | (f << 3) | (inv << 5) | (fall << 6));
        ud_neg = (f == 1) && !dir;
        p0 = pos_cmd;
        n0 = npulse;
        src_u.step(sdl_fmt_t'(f), dir, $urandom_range(5, 9));
        wt(3);
        chk("pos", pos_cmd, (dir ^ inv) ? p0 + g : p0 - g);
        chk("steps", 32'(npulse - n0), 1);
        chk("dir", step_dir, dir ^ inv);
        if (f != 2) chk("edge", lvl, !fall);
        chk("bypass", bypass, 1'b1);
      end
    end
    $display("test formats done");
    // Nonzero acceleration keeps smoothing; zero without the digital source stops motion
    wr(`SDL_CTRL, 32'h0);
    src_u.park();
    wr(`SDL_GEAR, 32'h1);
    wr(`SDL_ACCEL, 32'h5);
    wr(`SDL_CTRL, 32'h005);
    wt(2);
    chk("smooth", {mstop, bypass}, 2'b00);
    try_step(1'b1, 1'b1);
    wr(`SDL_ACCEL, 32'h0);
    wr(`SDL_ISTAT, 32'h7);
    wt(2);
    chk("stop", {mstop, bypass}, 2'b10);
    try_step(1'b1, 1'b0);
    rd(`SDL_ISTAT, d);
    chk("refused", d[1], 1'b1);
    wr(`SDL_ACCEL, 32'h0);
    $display("test accel done");
    // Limits, latch, re-enable, hold option and interrupt
    wr(`SDL_LSEL, 32'h5C2);
    rd(`SDL_LSEL, d);
    chk("lsel", d, 32'h5C2);
    wr(`SDL_IMASK, 32'h1);
    wr(`SDL_CTRL, 32'h105);
    din[2] <= 1'b1;
    wt(6);
    chk("warn", warn, 1'b1);
    chk("irq set", irq, 1'b1);
    rd(`SDL_STAT, d);
    chk("latch", {d[3], d[0]}, 2'b11);
    n0 = 0;
    for (int i = 0; i < 40; i++) begin
      lvl = led;
      wt(1);
      if (led !== lvl) n0++;
    end
    chk("fast blink", 32'(n0 >= 3), 1);
    try_step(1'b1, 1'b0);
    try_step(1'b0, 1'b0);
    wr(`SDL_ISTAT, 32'h7);
    wt(2);
    chk("irq clr", irq, 1'b0);
    wr(`SDL_CTRL, 32'h104);
    wr(`SDL_CTRL, 32'h105);
    wt(2);
    chk("away only", {ok_pos, ok_neg}, 2'b01);
    try_step(1'b1, 1'b0);
    try_step(1'b0, 1'b1);
    wr(`SDL_CTRL, 32'h185);
    wt(2);
    chk("hold", ok_neg, 1'b0);
    try_step(1'b0, 1'b0);
    wr(`SDL_CTRL, 32'h183);
    wt(2);
    chk("hold vel", {ok_pos, ok_neg}, 2'b11);
    wr(`SDL_CTRL, 32'h103);
    wt(2);
    chk("vel gate", {ok_pos, ok_neg, warn}, 3'b011);
    wr(`SDL_CTRL, 32'h101);
    wt(2);
    chk("cur gate", {ok_pos, ok_neg, warn}, 3'b010);
    wr(`SDL_CTRL, 32'h105);
    // Release one limit before raising the other, so the latch sees a new rise
    din[2] <= 1'b0;
    wt(6);
    din[12] <= 1'b1;
    wt(6);
    rd(`SDL_STAT, d);
    chk("neg latch", {d[3], d[1]}, 2'b11);
    wr(`SDL_CTRL, 32'h505);
    wt(2);
    rd(`SDL_STAT, d);
    chk("latch clr", d[3], 1'b0);
    din <= '0;
    $display("test limits done");
    // Home switch only on a network node
    wr(`SDL_CTRL, 32'h201);
    din[5] <= 1'b1;
    wt(6);
    chk("home on", home, 1'b1);
    chk("led on", led, 1'b1);
    wr(`SDL_CTRL, 32'h001);
    wt(2);
    chk("home off", home, 1'b0);
    $display("test home done");
    finish_test();
  end
endmodule : tb
